/* File: core/stt_pkg.sv */
// speculation tracking table: shared constants and carrier types
// assumes a single core clock and a synchronous active-high reset
//
// Overview of operation
// - every advanced load allocates a table entry, except a deferred one or one in a legacy entry cycle
// - lookup by physical address and by register tag
// - tag from register number, type, wrap state
// - pair load tags first target register only
// - allocation first removes same-tag entry
// - entry holds tag, size, address tag
// - advanced load writes target, base, prefetch
// - check load address and size must match (the table does not compare them; checks look up by register tag only)
// - check hit falls through, miss redirects
// - failing check: branch or emulating fault
// - false check failures allowed but rare
// - check load miss reloads, raises faults
// - check load hit leaves register unchanged
// - ordered clearing check load acquires
// - tag lookups obey memory ordering
// - size and replacement are implementation choices
// - legacy instruction set entry empties table
// - clearing checks and invalidates remove entries
// - local and remote stores trigger invalidation check
// - overlapping entries removed on store events
// - deferred token: drop same tag, no allocate
// - clearing check loads clear regardless of address
// - invalidate-all clears every entry at once
package stt_pkg;

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int REGNUM_W = 7;
  localparam int WRAP_W   = 2;
  localparam int TAG_W    = REGNUM_W + 1 + WRAP_W;
  localparam int PADDR_W  = 50;
  localparam int SIZE_W   = 4;
  localparam int ENTRIES  = 32;

  // ----------------------------------------------------------------
  // operation codes from the pipeline
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    STT_OP_NONE      = 4'h0,
    STT_OP_ADV_LOAD  = 4'h1,
    STT_OP_CHK_LOAD  = 4'h2,
    STT_OP_CHK_CLR   = 4'h3,
    STT_OP_CHK_ACQ   = 4'h4,
    STT_OP_ADV_CHK   = 4'h5,
    STT_OP_ADV_CHKC  = 4'h6,
    STT_OP_INV_ALL   = 4'h7,
    STT_OP_INV_ONE   = 4'h8
  } stt_op_type;

  typedef struct packed {
    stt_op_type          op;
    logic [REGNUM_W-1:0] reg_num;
    logic                reg_fp;
    logic                pair;
    logic [WRAP_W-1:0]   wrap;
    logic [PADDR_W-1:0]  paddr;
    logic [SIZE_W-1:0]   size;
    logic                deferred;
  } stt_req_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic redirect;
    logic reload;
    logic acquire;
    logic wr_target;
  } stt_rsp_type;

  typedef struct packed {
    logic               valid;
    logic               remote;
    logic [PADDR_W-1:0] paddr;
    logic [SIZE_W-1:0]  size;
  } stt_snoop_type;

  localparam logic [SIZE_W-1:0] SIZE_ONE = 4'h1;

endpackage

/* File: core/stt_table.sv */
// speculation tracking table: advanced load allocation, checks, invalidation
// assumes one request per cycle from the pipeline and a snoop port
// carrying local and remote stores and semaphores
`timescale 1ns/1ps
module stt_table #(
  parameter int ENTRIES = stt_pkg::ENTRIES
) (
  // clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  // pipeline requests
  input  wire stt_pkg::stt_req_type  req_i,
  input  wire logic                  legacy_entry_i,
  // store and semaphore events
  input  wire stt_pkg::stt_snoop_type snoop_i,
  // answers
  output stt_pkg::stt_rsp_type       rsp_o,
  output logic [ENTRIES-1:0]         valid_o
);
  localparam int IW = $clog2(ENTRIES);

  if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_bad_entries
    $error("entry count must be a power of two, at least two");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0]               vld_r;
  logic [ENTRIES-1:0]               vld_nxt;
  logic [stt_pkg::TAG_W-1:0]        tag_r   [ENTRIES];
  logic [stt_pkg::TAG_W-1:0]        tag_nxt [ENTRIES];
  logic [stt_pkg::PADDR_W-1:0]      addr_r  [ENTRIES];
  logic [stt_pkg::PADDR_W-1:0]      addr_nxt[ENTRIES];
  logic [stt_pkg::SIZE_W-1:0]       size_r  [ENTRIES];
  logic [stt_pkg::SIZE_W-1:0]       size_nxt[ENTRIES];
  stt_pkg::stt_rsp_type             rsp_r;
  stt_pkg::stt_rsp_type             rsp_nxt;

  logic [stt_pkg::TAG_W-1:0]        req_tag;
  logic [IW-1:0]                    victim;
  logic                             alloc;
  logic [ENTRIES-1:0]               tag_hit;
  logic [ENTRIES-1:0]               ovl_hit;
  logic                             any_hit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // half-open byte ranges [a, a+sa) and [b, b+sb) intersect
  function automatic logic overlap(
    input logic [stt_pkg::PADDR_W-1:0] a,
    input logic [stt_pkg::SIZE_W-1:0]  sa,
    input logic [stt_pkg::PADDR_W-1:0] b,
    input logic [stt_pkg::SIZE_W-1:0]  sb
  );
    logic [stt_pkg::PADDR_W:0] a_end;
    logic [stt_pkg::PADDR_W:0] b_end;
    a_end = {1'b0, a} + {{(stt_pkg::PADDR_W + 1 - stt_pkg::SIZE_W){1'b0}}, sa};
    b_end = {1'b0, b} + {{(stt_pkg::PADDR_W + 1 - stt_pkg::SIZE_W){1'b0}}, sb};
    return ({1'b0, a} < b_end) && ({1'b0, b} < a_end);
  endfunction

  function automatic logic is_clearing(input stt_pkg::stt_op_type op);
    return op == stt_pkg::STT_OP_CHK_CLR || op == stt_pkg::STT_OP_CHK_ACQ;
  endfunction

  // ----------------------------------------------------------------
  // tag former and victim choice
  // ----------------------------------------------------------------
  stt_tag_gen u_tag (
    .reg_num_i (req_i.reg_num),
    .reg_fp_i  (req_i.reg_fp),
    .wrap_i    (req_i.wrap),
    .tag_o     (req_tag)
  );

  assign alloc = req_i.op == stt_pkg::STT_OP_ADV_LOAD && !req_i.deferred
                 && !legacy_entry_i;

  stt_victim #(
    .N (ENTRIES)
  ) u_victim (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .valid_i   (vld_r & ~tag_hit),
    .alloc_i   (alloc),
    .victim_o  (victim)
  );

  // ----------------------------------------------------------------
  // lookups
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      tag_hit[i] = vld_r[i] && tag_r[i] == req_tag;
      ovl_hit[i] = vld_r[i] && snoop_i.valid
                   && overlap(addr_r[i], size_r[i], snoop_i.paddr, snoop_i.size);
    end
    any_hit = |tag_hit;
  end

  // ----------------------------------------------------------------
  // table update
  // ----------------------------------------------------------------
  always_comb begin
    vld_nxt = vld_r;
    for (int i = 0; i < ENTRIES; i++) begin
      tag_nxt[i]  = tag_r[i];
      addr_nxt[i] = addr_r[i];
      size_nxt[i] = size_r[i];
    end
    case (req_i.op)
      stt_pkg::STT_OP_ADV_LOAD: begin
        vld_nxt = vld_nxt & ~tag_hit;
        if (alloc) begin
          vld_nxt[victim]  = 1'b1;
          tag_nxt[victim]  = req_tag;
          addr_nxt[victim] = req_i.paddr;
          size_nxt[victim] = req_i.size;
        end
      end
      stt_pkg::STT_OP_CHK_CLR,
      stt_pkg::STT_OP_CHK_ACQ: begin
        vld_nxt = vld_nxt & ~tag_hit;
      end
      stt_pkg::STT_OP_ADV_CHKC: begin
        // clear only on fall-through, which is a hit
        vld_nxt = vld_nxt & ~tag_hit;
      end
      stt_pkg::STT_OP_INV_ONE: begin
        vld_nxt = vld_nxt & ~tag_hit;
      end
      stt_pkg::STT_OP_INV_ALL: begin
        vld_nxt = '0;
      end
      default: begin
        vld_nxt = vld_r;
      end
    endcase
    // every store or semaphore, local or remote, is checked
    vld_nxt = vld_nxt & ~ovl_hit;
    if (alloc) begin
      // a fresh allocation wins over a store that hits the slot it replaces
      vld_nxt[victim] = 1'b1;
    end
    if (legacy_entry_i) begin
      vld_nxt = '0;
    end
  end

  // ----------------------------------------------------------------
  // answers, one cycle after the request
  // ----------------------------------------------------------------
  always_comb begin
    rsp_nxt = '0;
    case (req_i.op)
      stt_pkg::STT_OP_ADV_LOAD: begin
        rsp_nxt.valid     = 1'b1;
        rsp_nxt.wr_target = 1'b1;
      end
      stt_pkg::STT_OP_CHK_LOAD,
      stt_pkg::STT_OP_CHK_CLR,
      stt_pkg::STT_OP_CHK_ACQ: begin
        // lookup sees the table in request order, after older stores
        rsp_nxt.valid     = 1'b1;
        rsp_nxt.hit       = any_hit;
        rsp_nxt.reload    = !any_hit;
        rsp_nxt.wr_target = !any_hit;
        rsp_nxt.acquire   = req_i.op == stt_pkg::STT_OP_CHK_ACQ;
      end
      stt_pkg::STT_OP_ADV_CHK,
      stt_pkg::STT_OP_ADV_CHKC: begin
        // a same-cycle snoop hit is reported as a failure
        rsp_nxt.valid    = 1'b1;
        rsp_nxt.hit      = |(tag_hit & ~ovl_hit);
        rsp_nxt.redirect = !rsp_nxt.hit;
      end
      default: begin
        rsp_nxt = '0;
      end
    endcase
    if (legacy_entry_i) begin
      rsp_nxt.hit      = 1'b0;
      rsp_nxt.redirect = rsp_nxt.valid && !is_clearing(req_i.op)
                         && req_i.op != stt_pkg::STT_OP_CHK_LOAD
                         && req_i.op != stt_pkg::STT_OP_ADV_LOAD;
      rsp_nxt.reload   = rsp_nxt.valid && !rsp_nxt.redirect
                         && req_i.op != stt_pkg::STT_OP_ADV_LOAD;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      vld_r <= '0;
      rsp_r <= '0;
    end else begin
      vld_r <= vld_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < ENTRIES; i++) begin
      tag_r[i]  <= tag_nxt[i];
      addr_r[i] <= addr_nxt[i];
      size_r[i] <= size_nxt[i];
    end
  end

  assign rsp_o   = rsp_r;
  assign valid_o = vld_r;

endmodule

/* File: core/stt_tag_gen.sv */
// register tag former for the speculation tracking table
// assumes combinational use within the core clock domain
`timescale 1ns/1ps
module stt_tag_gen (
  // register identity
  input  wire logic [stt_pkg::REGNUM_W-1:0] reg_num_i,
  input  wire logic                         reg_fp_i,
  input  wire logic [stt_pkg::WRAP_W-1:0]   wrap_i,
  // tag
  output logic      [stt_pkg::TAG_W-1:0]    tag_o
);
  // pair loads present their first target here only
  assign tag_o = {wrap_i, reg_fp_i, reg_num_i};
endmodule

/* File: core/stt_victim.sv */
// round-robin victim choice for the tracking table
// assumes the valid vector comes from the same clock domain
`timescale 1ns/1ps
module stt_victim #(
  parameter int N = 32
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 srst_i,
  // table state
  input  wire logic [N-1:0]         valid_i,
  input  wire logic                 alloc_i,
  // choice
  output logic      [$clog2(N)-1:0] victim_o
);
  localparam int IW = $clog2(N);

  if (N < 2) begin : g_bad_n
    $error("victim choice needs at least two entries");
  end

  logic [IW-1:0] ptr_r;
  logic [IW-1:0] ptr_nxt;
  logic [IW-1:0] free_idx;
  logic          free_found;

  // ----------------------------------------------------------------
  // free slot first, else rotating pointer
  // ----------------------------------------------------------------
  always_comb begin
    free_idx   = '0;
    free_found = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!valid_i[i]) begin
        free_idx   = IW'(i);
        free_found = 1'b1;
      end
    end
    victim_o = free_found ? free_idx : ptr_r;
    ptr_nxt  = ptr_r;
    if (alloc_i && !free_found) begin
      ptr_nxt = ptr_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end
endmodule

/* File: tb/stt_snoop_model.sv */
// store and semaphore event source standing for the coherence side
// assumes the core clock; events launch on the falling edge
`timescale 1ns/1ps
module stt_snoop_model (
  input  wire logic              ref_clk_i,
  output stt_pkg::stt_snoop_type snoop_o
);
  initial snoop_o = '0;
  // one event per call; released lines show the inverted address
  task automatic store(input logic remote, input logic [11:0] a, input logic [3:0] sz);
    @(negedge ref_clk_i);
    snoop_o = '{valid: 1'b1, remote: remote, paddr: {38'h0, a}, size: sz};
    @(negedge ref_clk_i);
    snoop_o = '{valid: 1'b0, remote: 1'b0, paddr: ~{38'h0, a}, size: ~sz};
  endtask
endmodule

/* File: tb/stt_table_bench.sv */
// self-checking bench for the speculation tracking table
// assumes the checker is bound in and the snoop model drives the event port
`timescale 1ns/1ps
module stt_table_bench;
  localparam int N = 8;
  localparam int AW = stt_pkg::PADDR_W;
  typedef struct packed {
    stt_pkg::stt_op_type op;
    logic [6:0]          rn;
    logic                pair;
    logic [11:0]         a;
    logic [3:0]          e;
  } stt_row_type;
  logic                   ref_clk_i = 1'b0;
  logic                   srst_i = 1'b1;
  stt_pkg::stt_req_type   req_i;
  logic                   legacy_entry_i;
  stt_pkg::stt_snoop_type snoop_i;
  stt_pkg::stt_rsp_type   rsp_o;
  stt_pkg::stt_rsp_type   got;
  logic [3:0]             got_bits;
  logic [N-1:0]           valid_o;
  int                     errors = 0;
  int                     compares = 0;
  // expected {hit, redirect, reload, wr_target} under the mask of each op
  stt_row_type rows[18] = '{
    '{stt_pkg::STT_OP_ADV_LOAD, 7'h5, 1'b0, 12'h100, 4'h1},
    '{stt_pkg::STT_OP_CHK_LOAD, 7'h5, 1'b0, 12'h100, 4'h8},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h5, 1'b0, 12'h100, 4'h8},
    '{stt_pkg::STT_OP_CHK_CLR, 7'h5, 1'b0, 12'h100, 4'h8},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h5, 1'b0, 12'h100, 4'h4},
    '{stt_pkg::STT_OP_CHK_LOAD, 7'h5, 1'b0, 12'h100, 4'h3},
    '{stt_pkg::STT_OP_ADV_LOAD, 7'h6, 1'b0, 12'h200, 4'h1},
    '{stt_pkg::STT_OP_INV_ONE, 7'h6, 1'b0, 12'h200, 4'h0},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h6, 1'b0, 12'h200, 4'h4},
    '{stt_pkg::STT_OP_ADV_LOAD, 7'h7, 1'b1, 12'h300, 4'h1},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h7, 1'b0, 12'h300, 4'h8},
    '{stt_pkg::STT_OP_CHK_ACQ, 7'h7, 1'b0, 12'h300, 4'h8},
    '{stt_pkg::STT_OP_ADV_LOAD, 7'h8, 1'b0, 12'h400, 4'h1},
    '{stt_pkg::STT_OP_INV_ALL, 7'h0, 1'b0, 12'h000, 4'h0},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h8, 1'b0, 12'h400, 4'h4},
    '{stt_pkg::STT_OP_ADV_LOAD, 7'h9, 1'b0, 12'h500, 4'h1},
    '{stt_pkg::STT_OP_ADV_CHKC, 7'h9, 1'b0, 12'h500, 4'h8},
    '{stt_pkg::STT_OP_ADV_CHK, 7'h9, 1'b0, 12'h500, 4'h4}};

  always #2 ref_clk_i = ~ref_clk_i;

  stt_table #(.ENTRIES(N)) dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i),
    .legacy_entry_i(legacy_entry_i), .snoop_i(snoop_i), .rsp_o(rsp_o), .valid_o(valid_o));
  stt_snoop_model snp_u (.ref_clk_i(ref_clk_i), .snoop_o(snoop_i));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  // one request held for one edge; answer taken while it stands
  task automatic req(input stt_pkg::stt_op_type op, input logic [6:0] rn, input logic [11:0] a,
                     input logic pair = 1'b0, input logic dfr = 1'b0);
    @(negedge ref_clk_i);
    req_i = '{op: op, reg_num: rn, reg_fp: 1'b0, pair: pair, wrap: 2'h0,
              paddr: AW'(a), size: 4'h8, deferred: dfr};
    @(negedge ref_clk_i);
    got = rsp_o;
    req_i.op = stt_pkg::STT_OP_NONE;
  endtask

  function automatic logic [3:0] mask(input stt_pkg::stt_op_type op);
    case (op)
      stt_pkg::STT_OP_ADV_LOAD: return 4'h1;
      stt_pkg::STT_OP_ADV_CHK, stt_pkg::STT_OP_ADV_CHKC: return 4'hc;
      stt_pkg::STT_OP_CHK_LOAD, stt_pkg::STT_OP_CHK_CLR, stt_pkg::STT_OP_CHK_ACQ: return 4'hb;
      default: return 4'h0;
    endcase
  endfunction

  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    errors++;
    test_done();
  end

  initial begin
    req_i = '0;
    legacy_entry_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    srst_i = 1'b0;
    check(valid_o === '0, "reset");
    for (int i = 0; i < 18; i++) begin
      req(rows[i].op, rows[i].rn, rows[i].a, rows[i].pair);
      got_bits = {got.hit, got.redirect, got.reload, got.wr_target} & mask(rows[i].op);
      check(got.valid === (mask(rows[i].op) != 4'h0) && got_bits === rows[i].e, "row");
    end
    $display("table rows done");
    req(stt_pkg::STT_OP_ADV_LOAD, 7'ha, 12'h600);
    snp_u.store(1'b1, 12'h604, 4'h1);
    req(stt_pkg::STT_OP_ADV_CHK, 7'ha, 12'h600);
    check(got.redirect === 1'b1, "overlapping remote store kept entry");
    req(stt_pkg::STT_OP_ADV_LOAD, 7'ha, 12'h600);
    snp_u.store(1'b0, 12'h608, 4'h4);
    req(stt_pkg::STT_OP_ADV_CHK, 7'ha, 12'h600);
    check(got.hit === 1'b1, "disjoint store removed entry");
    $display("store test done");
    req(stt_pkg::STT_OP_ADV_LOAD, 7'hb, 12'h700);
    req(stt_pkg::STT_OP_ADV_LOAD, 7'hb, 12'h800);
    snp_u.store(1'b0, 12'h800, 4'h8);
    req(stt_pkg::STT_OP_ADV_CHK, 7'hb, 12'h800);
    check(got.redirect === 1'b1, "same tag entry not replaced");
    req(stt_pkg::STT_OP_ADV_LOAD, 7'hc, 12'h900);
    req(stt_pkg::STT_OP_ADV_LOAD, 7'hc, 12'h900, 1'b0, 1'b1);
    req(stt_pkg::STT_OP_ADV_CHK, 7'hc, 12'h900);
    check(got.redirect === 1'b1, "deferred load left entry");
    $display("replace test done");
    req(stt_pkg::STT_OP_ADV_LOAD, 7'hd, 12'hb00);
    fork
      req(stt_pkg::STT_OP_ADV_CHK, 7'hd, 12'hb00);
      begin
        @(negedge ref_clk_i);
        legacy_entry_i = 1'b1;
        @(negedge ref_clk_i);
        legacy_entry_i = 1'b0;
      end
    join
    check(valid_o === '0, "legacy entry kept entries");
    check(got.redirect === 1'b1 && got.hit === 1'b0, "check hit across legacy entry");
    for (int i = 0; i <= N; i++) begin
      req(stt_pkg::STT_OP_ADV_LOAD, 7'(i + 16), 12'ha00);
    end
    check(valid_o === '1 && got.wr_target === 1'b1, "full table load");
    req(stt_pkg::STT_OP_ADV_CHK, 7'h18, 12'ha00);
    check(got.hit === 1'b1, "last load into full table lost");
    req(stt_pkg::STT_OP_ADV_CHK, 7'h10, 12'ha00);
    check(got.redirect === 1'b1, "round robin victim kept");
    @(negedge ref_clk_i);
    srst_i = 1'b1;
    @(negedge ref_clk_i);
    check(valid_o === '0 && rsp_o === '0, "mid-run reset");
    srst_i = 1'b0;
    $display("full and reset tests done");
    test_done();
  end
endmodule

/* File: tb/stt_table_props.sv */
// checker for the speculation tracking table, watching the top ports only
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module stt_table_props #(
  parameter int ENTRIES = 32
) (
  input wire logic                   ref_clk_i,
  input wire logic                   srst_i,
  input wire stt_pkg::stt_req_type   req_i,
  input wire logic                   legacy_entry_i,
  input wire stt_pkg::stt_snoop_type snoop_i,
  input wire stt_pkg::stt_rsp_type   rsp_o,
  input wire logic [ENTRIES-1:0]     valid_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic adv;
  // plain allocating advanced load with nothing else competing
  assign adv = req_i.op == stt_pkg::STT_OP_ADV_LOAD && !req_i.deferred && !legacy_entry_i
               && !snoop_i.valid;
  AST_ALLOC: assert property (adv |=> rsp_o.valid && rsp_o.wr_target && valid_o != '0)
    else $error("advanced load did not allocate");
  AST_IDLE: assert property (req_i.op == stt_pkg::STT_OP_NONE |=> !rsp_o.valid)
    else $error("answer without request");
  AST_RESET: assert property (disable iff (1'b0) srst_i |=> valid_o == '0 && rsp_o == '0)
    else $error("table not empty after reset");
  AST_INV_ALL: assert property (req_i.op == stt_pkg::STT_OP_INV_ALL |=> valid_o == '0)
    else $error("invalidate all left entries");
  AST_LEGACY: assert property (legacy_entry_i |=> valid_o == '0)
    else $error("legacy entry left entries");
  AST_CHK_BRANCH: assert property (req_i.op == stt_pkg::STT_OP_ADV_CHK |=>
    rsp_o.redirect != rsp_o.hit)
    else $error("check redirect does not follow hit");
  AST_CHK_LOAD: assert property (req_i.op inside {stt_pkg::STT_OP_CHK_LOAD,
    stt_pkg::STT_OP_CHK_CLR, stt_pkg::STT_OP_CHK_ACQ} |=>
    rsp_o.reload != rsp_o.hit && !(rsp_o.hit && rsp_o.wr_target))
    else $error("check load reload or write wrong");
  AST_ACQ: assert property (req_i.op == stt_pkg::STT_OP_CHK_ACQ |=> rsp_o.acquire)
    else $error("ordered check load not acquiring");
  AST_DEFER: assert property (req_i.op == stt_pkg::STT_OP_ADV_LOAD && req_i.deferred |=>
    (valid_o & ~$past(valid_o)) == '0 && rsp_o.wr_target)
    else $error("deferred load allocated");
  AST_FULL: assert property (valid_o == '1 && adv |=> valid_o == '1 && rsp_o.valid)
    else $error("full table dropped a load");
endmodule
bind stt_table stt_table_props #(.ENTRIES(ENTRIES)) props_u (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .req_i(req_i), .legacy_entry_i(legacy_entry_i), .snoop_i(snoop_i), .rsp_o(rsp_o),
  .valid_o(valid_o));
